//--- hw/eip_defines.svh
`ifndef EIP_DEFINES_SVH
`define EIP_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EIP_OFF_CTRL 8'h00
`define EIP_OFF_ENA 8'h04
`define EIP_OFF_FLAG 8'h08
`define EIP_OFF_PINS 8'h0c
`define EIP_OFF_IST 8'h10
`define EIP_OFF_ICLR 8'h14
`define EIP_OFF_IEN 8'h18

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define EIP_CTRL_RST 8'h00
`define EIP_BIT_SLEEP_ALLOW 7
`define EIP_SEL_HI 6
`define EIP_SEL_LO 4
`define EIP_SENSE_B_HI 3
`define EIP_SENSE_B_LO 2
`define EIP_SENSE_A_HI 1
`define EIP_SENSE_A_LO 0
`define EIP_BIT_PIN_A 6
`define EIP_EV_FLAG_A 0
`define EIP_EV_WAKE 2
`define EIP_EV_MISS 3
`define EIP_EV_W 4

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define EIP_CLK_PERIOD_NS 10
`define EIP_WDT_PERIOD_NS 1000
`define EIP_WDT_CYCLES (`EIP_WDT_PERIOD_NS / `EIP_CLK_PERIOD_NS)

`endif

//--- hw/eip_pkg.sv
package eip_pkg;

  typedef enum logic [1:0] {
    EIP_SNS_LOW = 2'h0,
    EIP_SNS_ANY = 2'h1,
    EIP_SNS_FALL = 2'h2,
    EIP_SNS_RISE = 2'h3
  } eip_sense_t;

  typedef enum logic [2:0] {
    EIP_WK_IDLE = 3'h1,
    EIP_WK_ARMED = 3'h2,
    EIP_WK_START = 3'h4
  } eip_wake_t;

endpackage

//--- hw/eip_det_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eip_det_if;
  import eip_pkg::*;
  logic pin;
  eip_sense_t sense;
  logic edge_evt;
  logic level_req;
  logic wake_evt;
  logic miss_evt;
  modport det (input pin, input sense, output edge_evt, output level_req,
               output wake_evt, output miss_evt);
  modport ctl (output pin, output sense, input edge_evt, input level_req,
               input wake_evt, input miss_evt);
endinterface
`default_nettype wire

//--- hw/eip_sense_det.sv
`timescale 1ns/10ps
`default_nettype none
module eip_sense_det
  import eip_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_io_run,
  input wire logic i_wdt_tick,
  input wire logic i_pwr_down,
  input wire logic i_startup_done,
  eip_det_if.det det
);

  logic samp_ff;
  logic prev_ff;
  logic [1:0] vld_ff;
  logic edge_hit;
  eip_wake_t state_ff;
  eip_wake_t nxt_state;

  // ---------------------------------------------------------------
  // sampling and edge detection
  // ---------------------------------------------------------------
  // samples only advance while the io clock runs
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      samp_ff <= 1'b0;
      prev_ff <= 1'b0;
      vld_ff <= 2'h0;
    end else if (i_io_run) begin
      samp_ff <= det.pin;
      prev_ff <= samp_ff;
      vld_ff <= {vld_ff[0], 1'b1};
    end
  end

  always_comb begin
    case (det.sense)
      EIP_SNS_ANY: edge_hit = samp_ff ^ prev_ff;
      EIP_SNS_FALL: edge_hit = prev_ff & ~samp_ff;
      EIP_SNS_RISE: edge_hit = ~prev_ff & samp_ff;
      default: edge_hit = 1'b0;
    endcase
  end

  // no history right after reset, so no false edge from the reset value
  assign det.edge_evt = i_io_run & vld_ff[1] & edge_hit;
  // clockless path: works in every sleep state
  assign det.level_req = (det.sense == EIP_SNS_LOW) & ~det.pin;

  // ---------------------------------------------------------------
  // power-down wake sampling
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EIP_WK_IDLE: begin
        if (i_pwr_down && det.sense == EIP_SNS_LOW && i_wdt_tick && !det.pin) begin
          nxt_state = EIP_WK_ARMED;
        end
      end
      EIP_WK_ARMED: begin
        if (!i_pwr_down) begin
          nxt_state = EIP_WK_IDLE;
        end else if (i_wdt_tick) begin
          nxt_state = det.pin ? EIP_WK_IDLE : EIP_WK_START;
        end
      end
      EIP_WK_START: begin
        if (i_startup_done) begin
          nxt_state = EIP_WK_IDLE;
        end
      end
      default: nxt_state = EIP_WK_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_ff <= EIP_WK_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign det.wake_evt = (state_ff == EIP_WK_ARMED) & i_pwr_down & i_wdt_tick & ~det.pin;
  // woke up, but the level left before start-up ended
  assign det.miss_evt = (state_ff == EIP_WK_START) & i_startup_done & det.pin;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_first_low;
    state_ff == EIP_WK_IDLE && i_pwr_down && det.sense == EIP_SNS_LOW && i_wdt_tick && !det.pin;
  endsequence
  sequence s_second_low;
    i_pwr_down && i_wdt_tick && !det.pin;
  endsequence

  // the window ends at the very next watchdog tick, so a later low sample cannot match
  AST_WAKE_TWO: assert property (s_first_low ##1 (!i_wdt_tick)[*1] ##[0:99] s_second_low
      |-> det.wake_evt) else $error("second low sample gave no wake");
  AST_MISS_HIGH: assert property (det.miss_evt |-> det.pin && $past(state_ff) != EIP_WK_IDLE)
    else $error("miss event without high pin");
  AST_EDGE_IO: assert property (!i_io_run |-> !det.edge_evt)
    else $error("edge while io clock stopped");
  AST_LEVEL_ASYNC: assert property (det.sense == EIP_SNS_LOW && !det.pin |-> det.level_req)
    else $error("low level not requested");

endmodule
`default_nettype wire

//--- hw/eip_ext_irq_unit.sv
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`include "eip_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module eip_ext_irq_unit
  import eip_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic i_io_clk_run,
  input wire logic i_core_global_ie,
  input wire logic i_irq_taken_a,
  input wire logic i_irq_taken_b,
  input wire logic i_pwr_down,
  input wire logic i_startup_done,
  output logic o_irq_req_a,
  output logic o_irq_req_b,
  output logic o_wake_req,
  output logic o_sleep_allow,
  output logic [2:0] o_sleep_sel,
  output logic o_irq
);

  localparam logic [6:0] WDT_LAST = 7'(`EIP_WDT_CYCLES - 1);

  logic [7:0] ctrl_ff;
  logic [1:0] ena_ff;
  logic [1:0] flag_ff;
  logic [`EIP_EV_W-1:0] ist_ff;
  logic [`EIP_EV_W-1:0] ien_ff;
  logic [`EIP_EV_W-1:0] ev;
  logic [6:0] wdt_cnt_ff;
  logic wdt_tick_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wake_ff;
  logic req;
  logic wr_go;
  logic [1:0] pins;
  logic [1:0] taken;
  logic [1:0] edge_evt;
  logic [1:0] level_req;
  logic [1:0] wake_evt;
  logic [1:0] miss_evt;
  logic [1:0] flag_set;
  logic [1:0] irq_req;
  eip_sense_t sense [2];

  // ---------------------------------------------------------------
  // avalon slave handshake
  // ---------------------------------------------------------------
  // one wait state: data is registered first, then waitrequest drops
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_ff;
  assign wr_go = i_avs_write & ack_ff;
  assign o_avs_readdata = rdata_ff;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0;
    case (i_avs_address)
      `EIP_OFF_CTRL: nxt_rdata = {24'h0, ctrl_ff};
      `EIP_OFF_ENA: nxt_rdata = {24'h0, ena_ff, 6'h0};
      // a pin's flag bit reads back zero while that pin is in level mode
      `EIP_OFF_FLAG: nxt_rdata = {24'h0, flag_ff, 6'h0};
      `EIP_OFF_PINS: nxt_rdata = {28'h0, level_req, pins};
      `EIP_OFF_IST: nxt_rdata = {28'h0, ist_ff};
      `EIP_OFF_IEN: nxt_rdata = {28'h0, ien_ff};
      default: nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_ff <= 32'h0;
    end else if (i_avs_read && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // control and enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_ff <= `EIP_CTRL_RST;
    end else if (wr_go && i_avs_address == `EIP_OFF_CTRL) begin
      ctrl_ff <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ena_ff <= 2'h0;
    end else if (wr_go && i_avs_address == `EIP_OFF_ENA) begin
      ena_ff <= i_avs_writedata[`EIP_BIT_PIN_A+1:`EIP_BIT_PIN_A];
    end
  end

  assign o_sleep_allow = ctrl_ff[`EIP_BIT_SLEEP_ALLOW];
  assign o_sleep_sel = ctrl_ff[`EIP_SEL_HI:`EIP_SEL_LO];
  assign sense[0] = eip_sense_t'(ctrl_ff[`EIP_SENSE_A_HI:`EIP_SENSE_A_LO]);
  assign sense[1] = eip_sense_t'(ctrl_ff[`EIP_SENSE_B_HI:`EIP_SENSE_B_LO]);

  // ---------------------------------------------------------------
  // watchdog oscillator rate
  // ---------------------------------------------------------------
  // stands in for the slow oscillator as an enable, one per microsecond
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wdt_cnt_ff <= 7'h0;
      wdt_tick_ff <= 1'b0;
    end else begin
      wdt_tick_ff <= (wdt_cnt_ff == WDT_LAST);
      if (wdt_cnt_ff == WDT_LAST) begin
        wdt_cnt_ff <= 7'h0;
      end else begin
        wdt_cnt_ff <= wdt_cnt_ff + 7'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-pin detection, flags and requests
  // ---------------------------------------------------------------
  // the pad value is used whatever the port direction is
  assign pins = {i_ext_irq_pin_b, i_ext_irq_pin_a};
  assign taken = {i_irq_taken_b, i_irq_taken_a};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    eip_det_if u_if ();

    assign u_if.pin = pins[i];
    assign u_if.sense = sense[i];
    assign edge_evt[i] = u_if.edge_evt;
    assign level_req[i] = u_if.level_req;
    assign wake_evt[i] = u_if.wake_evt;
    assign miss_evt[i] = u_if.miss_evt;

    eip_sense_det u_det (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_io_run(i_io_clk_run),
      .i_wdt_tick(wdt_tick_ff),
      .i_pwr_down(i_pwr_down),
      .i_startup_done(i_startup_done),
      .det(u_if.det)
    );

    assign flag_set[i] = edge_evt[i] & (sense[i] != EIP_SNS_LOW);

    // a set in the same cycle as a clear wins
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        flag_ff[i] <= 1'b0;
      end else if (sense[i] == EIP_SNS_LOW) begin
        flag_ff[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flag_ff[i] <= 1'b1;
      end else if (taken[i]) begin
        flag_ff[i] <= 1'b0;
      end else if (wr_go && i_avs_address == `EIP_OFF_FLAG
                   && i_avs_writedata[`EIP_BIT_PIN_A+i]) begin
        flag_ff[i] <= 1'b0;
      end
    end

    // level mode follows the pin with no clock in the path
    assign irq_req[i] = i_core_global_ie & ena_ff[i]
                        & ((sense[i] == EIP_SNS_LOW) ? level_req[i] : flag_ff[i]);
  end

  assign o_irq_req_a = irq_req[0];
  assign o_irq_req_b = irq_req[1];

  // ---------------------------------------------------------------
  // wake output
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= |wake_evt;
    end
  end

  assign o_wake_req = wake_ff;

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  assign ev[`EIP_EV_FLAG_A+1:`EIP_EV_FLAG_A] = flag_set;
  assign ev[`EIP_EV_WAKE] = |wake_evt;
  assign ev[`EIP_EV_MISS] = |miss_evt;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ist_ff <= '0;
    end else if (wr_go && i_avs_address == `EIP_OFF_ICLR) begin
      ist_ff <= ev | (ist_ff & ~i_avs_writedata[`EIP_EV_W-1:0]);
    end else begin
      ist_ff <= ev | ist_ff;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ien_ff <= '0;
    end else if (wr_go && i_avs_address == `EIP_OFF_IEN) begin
      ien_ff <= i_avs_writedata[`EIP_EV_W-1:0];
    end
  end

  assign o_irq = |(ist_ff & ien_ff);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_change_a;
    i_io_clk_run && $past(i_io_clk_run) && $past(i_rst_n)
      && sense[0] == EIP_SNS_ANY && $changed(i_ext_irq_pin_a);
  endsequence

  AST_REQ_GATED: assert property (o_irq_req_a |-> i_core_global_ie && ena_ff[0])
    else $error("request without both enables");
  AST_LEVEL_HOLD: assert property (sense[0] == EIP_SNS_LOW && i_core_global_ie && ena_ff[0]
      && !i_ext_irq_pin_a |-> o_irq_req_a)
    else $error("low level not requested");
  AST_FLAG_LEVEL: assert property (flag_ff[0] |-> $past(sense[0]) != EIP_SNS_LOW)
    else $error("flag set in level mode");
  AST_FLAG_SET: assert property (flag_set[1] |=> flag_ff[1])
    else $error("edge did not set flag");
  AST_CHANGE_SEEN: assert property (s_change_a ##1 (i_io_clk_run && sense[0] == EIP_SNS_ANY)
      |-> edge_evt[0])
    else $error("change not detected");
  AST_BUS_WAIT: assert property ((i_avs_read && o_avs_waitrequest) ##1 i_avs_read
      |-> !o_avs_waitrequest)
    else $error("read not answered in one wait");
  AST_IST_STICKY: assert property (ist_ff[`EIP_EV_WAKE] && !wr_go |=> ist_ff[`EIP_EV_WAKE])
    else $error("status bit lost");

endmodule
`default_nettype wire

//--- verif/eip_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
module eip_pin_src (
  input wire logic i_mclk,
  output logic o_pin_a,
  output logic o_pin_b
);
  // ----------
  // pin sources
  // ----------
  // idle high, so a low-level mode sees no request until a source pulls low
  initial begin
    o_pin_a = 1'b1;
    o_pin_b = 1'b1;
  end
  // levels change just after an edge and stand for whole cycles only
  task automatic drive(input int which, input logic lvl, input int cycles);
    if (which == 0) begin
      o_pin_a <= lvl;
    end else begin
      o_pin_b <= lvl;
    end
    repeat (cycles) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

//--- verif/test_eip_ext_irq_unit.sv
`include "eip_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module test_eip_ext_irq_unit
  import eip_pkg::*;
;
  // ----------
  // signals
  // ----------
  logic i_mclk, i_rst_n, i_avs_read, i_avs_write, i_io_clk_run, i_core_global_ie;
  logic i_irq_taken_a, i_irq_taken_b, i_pwr_down, i_startup_done;
  logic i_ext_irq_pin_a, i_ext_irq_pin_b, o_avs_waitrequest;
  logic o_irq_req_a, o_irq_req_b, o_wake_req, o_sleep_allow, o_irq;
  logic [2:0] o_sleep_sel;
  logic [7:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  int bad_count;
  int checked;
  eip_ext_irq_unit i_eip_ext_irq_unit (.i_mclk, .i_rst_n, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_ext_irq_pin_a,
    .i_ext_irq_pin_b, .i_io_clk_run, .i_core_global_ie, .i_irq_taken_a, .i_irq_taken_b,
    .i_pwr_down, .i_startup_done, .o_irq_req_a, .o_irq_req_b, .o_wake_req, .o_sleep_allow,
    .o_sleep_sel, .o_irq);
  eip_pin_src i_eip_pin_src (.i_mclk(i_mclk), .o_pin_a(i_ext_irq_pin_a),
    .o_pin_b(i_ext_irq_pin_b));
  // ----------
  // tasks
  // ----------
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cw(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", s, e, g);
    end
  endtask
  task automatic cb(input string s, input logic e, input logic g);
    cw(s, {31'h0, e}, {31'h0, g});
  endtask
  // request held until waitrequest is sampled low; one idle edge follows
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge i_mclk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    {i_avs_read, i_avs_write} <= 2'b00;
    @(posedge i_mclk);
    if (n == 20) begin
      bad_count++;
      $display("[FAIL] bus exp answer seen none");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    cw(s, e, q);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_regs();
    rc("ctrl rst", `EIP_OFF_CTRL, 32'h0);
    rc("ena rst", `EIP_OFF_ENA, 32'h0);
    rc("flag rst", `EIP_OFF_FLAG, 32'h0);
    wr(8'h40, 32'hff);
    rc("unmapped", 8'h40, 32'h0);
    wr(`EIP_OFF_CTRL, 32'hd0);
    rc("ctrl rw", `EIP_OFF_CTRL, 32'hd0);
    cb("sleep allow", 1'b1, o_sleep_allow);
    cw("sleep sel", 32'h5, {29'h0, o_sleep_sel});
    wr(`EIP_OFF_ENA, 32'hc0);
    rc("ena rw", `EIP_OFF_ENA, 32'hc0);
    $display("test regs done");
  endtask
  task automatic t_edges();
    logic [31:0] k;
    i_core_global_ie <= 1'b1;
    i_io_clk_run <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        k = (p != 0) ? 32'h80 : 32'h40;
        wr(`EIP_OFF_CTRL, (p != 0) ? 32'(m << 2) : 32'(m));
        wr(`EIP_OFF_FLAG, 32'hc0);
        i_eip_pin_src.drive(p, 1'b0, 2);
        i_eip_pin_src.drive(p, 1'b0, 2);
        cb("req fall", m != 3, (p != 0) ? o_irq_req_b : o_irq_req_a);
        rc("flag fall", `EIP_OFF_FLAG, (m != 3) ? k : 32'h0);
        wr(`EIP_OFF_FLAG, 32'hc0);
        rc("flag w1c", `EIP_OFF_FLAG, 32'h0);
        i_eip_pin_src.drive(p, 1'b1, 4);
        rc("flag rise", `EIP_OFF_FLAG, (m != 2) ? k : 32'h0);
      end
    end
    $display("test edges done");
  endtask
  task automatic t_mask();
    wr(`EIP_OFF_CTRL, {24'h0, 6'h0, EIP_SNS_ANY});
    wr(`EIP_OFF_FLAG, 32'hc0);
    wr(`EIP_OFF_ICLR, 32'hf);
    i_core_global_ie <= 1'b0;
    i_eip_pin_src.drive(0, 1'b0, 4);
    cb("req no ie", 1'b0, o_irq_req_a);
    i_core_global_ie <= 1'b1;
    @(posedge i_mclk);
    cb("req ie", 1'b1, o_irq_req_a);
    wr(`EIP_OFF_ENA, 32'h0);
    cb("req masked", 1'b0, o_irq_req_a);
    wr(`EIP_OFF_ENA, 32'h40);
    rc("ist", `EIP_OFF_IST, 32'h1);
    cb("irq off", 1'b0, o_irq);
    wr(`EIP_OFF_IEN, 32'h1);
    cb("irq on", 1'b1, o_irq);
    {i_irq_taken_a, i_irq_taken_b} <= 2'b11;
    @(posedge i_mclk);
    {i_irq_taken_a, i_irq_taken_b} <= 2'b00;
    @(posedge i_mclk);
    rc("flag taken", `EIP_OFF_FLAG, 32'h0);
    wr(`EIP_OFF_ICLR, 32'h1);
    rc("ist clr", `EIP_OFF_IST, 32'h0);
    cb("irq clr", 1'b0, o_irq);
    $display("test mask done");
  endtask
  // pin a is still low here; the level request must not need the io clock
  task automatic t_level();
    wr(`EIP_OFF_CTRL, 32'h0);
    i_io_clk_run <= 1'b0;
    repeat (5) begin
      @(posedge i_mclk);
      cb("level req", 1'b1, o_irq_req_a);
    end
    rc("level flag", `EIP_OFF_FLAG, 32'h0);
    rc("pins", `EIP_OFF_PINS, 32'h6);
    i_eip_pin_src.drive(0, 1'b1, 2);
    cb("level off", 1'b0, o_irq_req_a);
    $display("test level done");
  endtask
  task automatic t_sleep();
    int seen;
    seen = 0;
    i_pwr_down <= 1'b1;
    wr(`EIP_OFF_CTRL, {24'h0, 6'h0, EIP_SNS_FALL});
    i_eip_pin_src.drive(0, 1'b0, 1);
    repeat (250) begin
      @(posedge i_mclk);
      seen += int'(o_wake_req === 1'b1);
    end
    cw("edge wake", 32'h0, 32'(seen));
    rc("flag no io clk", `EIP_OFF_FLAG, 32'h0);
    i_eip_pin_src.drive(0, 1'b1, 2);
    $display("test sleep done");
  endtask
  task automatic t_wake();
    int n;
    wr(`EIP_OFF_CTRL, 32'h0);
    wr(`EIP_OFF_ICLR, 32'hf);
    i_eip_pin_src.drive(0, 1'b0, 1);
    for (n = 0; n < 400; n++) begin
      @(posedge i_mclk);
      if (o_wake_req === 1'b1) break;
    end
    cb("two samples", 1'b1, n >= 99);
    @(posedge i_mclk);
    cb("wake pulse", 1'b0, o_wake_req);
    rc("ist wake", `EIP_OFF_IST, 32'h4);
    i_eip_pin_src.drive(0, 1'b1, 2);
    i_startup_done <= 1'b1;
    @(posedge i_mclk);
    i_startup_done <= 1'b0;
    @(posedge i_mclk);
    rc("ist no irq", `EIP_OFF_IST, 32'hc);
    cb("req gone", 1'b0, o_irq_req_a);
    i_pwr_down <= 1'b0;
    if (n == 400) begin
      bad_count++;
      $display("[FAIL] wake exp pulse seen none");
      end_of_test();
    end
    $display("test wake done");
  endtask
  // ----------
  // main
  // ----------
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    {i_rst_n, i_avs_read, i_avs_write, i_io_clk_run, i_core_global_ie} = '0;
    {i_irq_taken_a, i_irq_taken_b, i_pwr_down, i_startup_done} = '0;
    i_avs_address = 8'h0;
    i_avs_writedata = 32'h0;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    t_regs();
    t_edges();
    t_mask();
    t_level();
    t_sleep();
    t_wake();
    end_of_test();
  end
endmodule
`default_nettype wire
